// [mml_pkg.sv]
package mml_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PAGE_W      = 2;
  localparam int unsigned NUM_PAGES   = 4;
  localparam int unsigned LOWER_BYTES = 128;
  localparam int unsigned PAGE_BYTES  = 128;
  localparam int unsigned NUM_FLAGS   = 8;
  localparam int unsigned NUM_OUTS    = 8;
  // apb byte addresses of the register words
  localparam logic [11:0] APB_ADDR   = 12'h000;
  localparam logic [11:0] APB_WDATA  = 12'h004;
  localparam logic [11:0] APB_CMD    = 12'h008;
  localparam logic [11:0] APB_RDATA  = 12'h00c;
  localparam logic [11:0] APB_PAGE   = 12'h010;
  localparam logic [11:0] APB_EVENT  = 12'h014;
  localparam logic [11:0] APB_LATCH  = 12'h018;
  localparam logic [11:0] APB_MASK   = 12'h01c;
  localparam logic [11:0] APB_POWER  = 12'h020;
  localparam logic [11:0] APB_DIS    = 12'h024;
  localparam logic [11:0] APB_SQL    = 12'h028;
  localparam logic [11:0] APB_AUTO   = 12'h02c;
  localparam logic [11:0] APB_MUTE   = 12'h030;
  localparam logic [11:0] APB_ISTAT  = 12'h034;
  localparam logic [11:0] APB_IMASK  = 12'h038;
  // lower-memory byte addresses holding the latches, the masks and the power mode
  localparam logic [7:0]  LATCH_BYTE = 8'h08;
  localparam logic [7:0]  MASK_BYTE  = 8'h20;
  localparam logic [7:0]  POWER_BYTE = 8'h1a;
  localparam int unsigned CMD_RD_BIT = 0;
  localparam int unsigned CMD_WR_BIT = 1;
  localparam int unsigned ISTAT_RD   = 0;
  localparam int unsigned ISTAT_WR   = 1;
  localparam int unsigned ISTAT_FLAG = 2;
  localparam int unsigned ISTAT_W    = 3;
  localparam logic        LOW_POWER  = 1'b1;
  typedef enum logic [2:0] {
    MML_IDLE = 3'b001,
    MML_READ = 3'b010,
    MML_WRIT = 3'b100
  } mml_state_t;
endpackage : mml_pkg

// [mml_mem_if.sv]
`timescale 1ns/100ps
interface mml_mem_if;
  import mml_pkg::*;
  logic              we;
  logic [PAGE_W-1:0] page;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output we, output page, output addr, output wdata, input rdata);
  modport mem  (input we, input page, input addr, input wdata, output rdata);
endinterface : mml_mem_if

// [mml_mem.sv]
`timescale 1ns/100ps
module mml_mem (
  input  wire logic i_clk_sys,
  input  wire logic i_resetn,
  mml_mem_if.mem    port
);
  import mml_pkg::*;
  logic [DATA_W-1:0] lower [LOWER_BYTES];
  logic [DATA_W-1:0] upper [NUM_PAGES*PAGE_BYTES];
  logic [6:0]        offs;
  logic [8:0]        uidx;

  assign offs = port.addr[6:0];
  assign uidx = {port.page, offs};

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < LOWER_BYTES; i++) begin
        lower[i] <= 8'h00;
      end
      for (int j = 0; j < NUM_PAGES*PAGE_BYTES; j++) begin
        upper[j] <= 8'h00;
      end
    end else if (port.we) begin
      if (!port.addr[7]) begin
        lower[offs] <= port.wdata;
      end else begin
        upper[uidx] <= port.wdata;
      end
    end
  end

  // combinational read; the controller registers the result
  always_comb begin
    if (!port.addr[7]) begin
      port.rdata = lower[offs];
    end else begin
      port.rdata = upper[uidx];
    end
  end
endmodule : mml_mem

// [mml_top.sv]
`timescale 1ns/100ps
module mml_top (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_resetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [mml_pkg::NUM_OUTS-1:0] i_no_input,
  output logic                      o_int_req,
  output logic                      o_irq,
  output logic                      o_low_power,
  output logic [mml_pkg::NUM_OUTS-1:0] o_out_mute
);
  import mml_pkg::*;

  mml_mem_if mport ();

  mml_state_t        state;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [DATA_W-1:0] acc_rdata;
  logic [PAGE_W-1:0] page_sel;
  logic [NUM_FLAGS-1:0] latch;
  logic [NUM_FLAGS-1:0] fmask;
  logic              power_low;
  logic [NUM_OUTS-1:0] out_dis;
  logic [NUM_OUTS-1:0] out_sql;
  logic [NUM_OUTS-1:0] auto_en;
  logic [ISTAT_W-1:0] istat;
  logic [ISTAT_W-1:0] imask;
  logic [NUM_FLAGS-1:0] ev_pulse;
  logic              wr_en;
  logic              rd_en;
  logic              mm_rd_done;
  logic              mm_wr_done;
  logic              latch_clr;
  logic [ISTAT_W-1:0] ev_set;
  logic [DATA_W-1:0] mm_rdata;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // memory access engine: one cycle per byte operation
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= MML_IDLE;
    end else begin
      case (state)
        MML_IDLE: begin
          if (wr_en && paddr == APB_CMD && pwdata[CMD_WR_BIT]) begin
            state <= MML_WRIT;
          end else if (wr_en && paddr == APB_CMD && pwdata[CMD_RD_BIT]) begin
            state <= MML_READ;
          end
        end
        MML_READ: state <= MML_IDLE;
        MML_WRIT: state <= MML_IDLE;
        default:  state <= MML_IDLE;
      endcase
    end
  end

  assign mm_rd_done = (state == MML_READ);
  assign mm_wr_done = (state == MML_WRIT);
  assign latch_clr  = mm_rd_done && (acc_addr == LATCH_BYTE);

  // special bytes of lower memory are served by live registers
  always_comb begin
    if (acc_addr == LATCH_BYTE) begin
      mm_rdata = latch;
    end else if (acc_addr == MASK_BYTE) begin
      mm_rdata = fmask;
    end else if (acc_addr == POWER_BYTE) begin
      mm_rdata = {7'h00, power_low};
    end else begin
      mm_rdata = mport.rdata;
    end
  end

  assign mport.we    = mm_wr_done && (acc_addr != LATCH_BYTE);
  assign mport.page  = page_sel;
  assign mport.addr  = acc_addr;
  assign mport.wdata = acc_wdata;

  mml_mem u_mem (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .port      (mport)
  );

  // host-side setup registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_addr  <= 8'h00;
      acc_wdata <= 8'h00;
      page_sel  <= '0;
    end else if (wr_en) begin
      if (paddr == APB_ADDR) begin
        acc_addr <= pwdata[ADDR_W-1:0];
      end
      if (paddr == APB_WDATA) begin
        acc_wdata <= pwdata[DATA_W-1:0];
      end
      if (paddr == APB_PAGE) begin
        page_sel <= pwdata[PAGE_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_rdata <= 8'h00;
    end else if (mm_rd_done) begin
      acc_rdata <= mm_rdata;
    end
  end

  // event inputs come from the apb event word as one-cycle pulses
  assign ev_pulse = (wr_en && paddr == APB_EVENT) ? pwdata[NUM_FLAGS-1:0] : '0;

  // latches: set wins over clear-on-read
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      latch <= '0;
    end else begin
      latch <= (latch & ~(latch_clr ? latch : '0)) | ev_pulse;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fmask <= '0;
    end else if (mm_wr_done && acc_addr == MASK_BYTE) begin
      fmask <= acc_wdata;
    end else if (wr_en && paddr == APB_MASK) begin
      fmask <= pwdata[NUM_FLAGS-1:0];
    end
  end

  assign o_int_req = |(latch & ~fmask);

  // power mode: low after reset, memory still fully accessible
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      power_low <= LOW_POWER;
    end else if (mm_wr_done && acc_addr == POWER_BYTE) begin
      power_low <= acc_wdata[0];
    end else if (wr_en && paddr == APB_POWER) begin
      power_low <= pwdata[0];
    end
  end
  assign o_low_power = power_low;

  // muting controls, each cleared only by its own control
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      out_dis <= '0;
      out_sql <= '0;
      auto_en <= '0;
    end else if (wr_en) begin
      if (paddr == APB_DIS) begin
        out_dis <= pwdata[NUM_OUTS-1:0];
      end
      if (paddr == APB_SQL) begin
        out_sql <= pwdata[NUM_OUTS-1:0];
      end
      if (paddr == APB_AUTO) begin
        auto_en <= pwdata[NUM_OUTS-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUTS; g++) begin : g_mute
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          o_out_mute[g] <= 1'b1;
        end else begin
          o_out_mute[g] <= out_dis[g] | out_sql[g] | (auto_en[g] & i_no_input[g]);
        end
      end
    end
  endgenerate

  // block interrupt: completion and flag events
  assign ev_set = {|ev_pulse, mm_wr_done, mm_rd_done};

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      istat <= '0;
    end else if (wr_en && paddr == APB_ISTAT) begin
      istat <= (istat & ~pwdata[ISTAT_W-1:0]) | ev_set;
    end else begin
      istat <= istat | ev_set;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      imask <= '0;
    end else if (wr_en && paddr == APB_IMASK) begin
      imask <= pwdata[ISTAT_W-1:0];
    end
  end

  assign o_irq = |(istat & imask);

  // apb read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        APB_ADDR:  prdata = {24'h000000, acc_addr};
        APB_WDATA: prdata = {24'h000000, acc_wdata};
        APB_CMD:   prdata = {31'h00000000, state != MML_IDLE};
        APB_RDATA: prdata = {24'h000000, acc_rdata};
        APB_PAGE:  prdata = {30'h00000000, page_sel};
        APB_LATCH: prdata = {24'h000000, latch};
        APB_MASK:  prdata = {24'h000000, fmask};
        APB_POWER: prdata = {31'h00000000, power_low};
        APB_DIS:   prdata = {24'h000000, out_dis};
        APB_SQL:   prdata = {24'h000000, out_sql};
        APB_AUTO:  prdata = {24'h000000, auto_en};
        APB_MUTE:  prdata = {24'h000000, o_out_mute};
        APB_ISTAT: prdata = {29'h00000000, istat};
        APB_IMASK: prdata = {29'h00000000, imask};
        default:   prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule : mml_top

// [mml_chk_sva.sv]
`timescale 1ns/100ps
module mml_chk (
  input wire logic                         i_clk_sys,
  input wire logic                         i_resetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         o_int_req,
  input wire logic                         o_irq,
  input wire logic                         o_low_power,
  input wire logic [mml_pkg::NUM_OUTS-1:0] o_out_mute
);
  import mml_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic wr;
  assign wr = psel && penable && pwrite;
  a_req_sticky: assert property (o_int_req && !wr && !$past(wr) |=> o_int_req)
    else $error("request dropped");
  a_mask_stops: assert property (wr && paddr == APB_MASK && pwdata[7:0] == 8'hff
    |=> !o_int_req) else $error("masked request");
  a_req_level: assert property (wr && paddr == APB_MASK && pwdata[7:0] == 8'h00
    ##1 !wr [*2] ##1 wr && paddr == APB_EVENT && pwdata[7:0] != 8'h00 |=> o_int_req)
    else $error("request missing");
  a_power_write: assert property (wr && paddr == APB_POWER
    |=> o_low_power == $past(pwdata[0])) else $error("power mode");
  a_power_hold: assert property (!wr && !$past(wr) |=> $stable(o_low_power))
    else $error("power moved");
  a_mute_dis: assert property (wr && paddr == APB_DIS && pwdata[7:0] == 8'hff
    ##1 !wr |=> o_out_mute == 8'hff) else $error("mute");
  a_irq_off: assert property (wr && paddr == APB_IMASK && pwdata[2:0] == 3'b000
    |=> !o_irq) else $error("irq");
  a_unmapped_zero: assert property (psel && penable && !pwrite && paddr == 12'h03c
    |-> prdata == 32'h0) else $error("unmapped");
  a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
    else $error("wait");
  c_req: cover property ($rose(o_int_req));
  c_irq: cover property ($rose(o_irq));
  c_pwr: cover property ($fell(o_low_power));
endmodule : mml_chk

// [mml_host.sv]
`timescale 1ns/100ps
module mml_host (
  input  wire logic        i_clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // one byte or word per transfer; idle data shows the inverse
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : mml_host

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import mml_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, o_int_req, o_irq, o_low_power;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, r;
  logic [7:0] a, v, i_no_input = 8'h00, o_out_mute;
  int fail_count = 0, check_count = 0, cyc = 0, p, k, mem[int], qk[$];
  logic [7:0] qa[$];
  mml_host mml_host_inst (.i_clk_sys(i_clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
  mml_top mml_top_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_no_input(i_no_input), .o_int_req(o_int_req),
    .o_irq(o_irq), .o_low_power(o_low_power), .o_out_mute(o_out_mute));
  initial forever #2.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    mml_host_inst.xfer(1'b1, ad, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] ad);
    mml_host_inst.xfer(1'b0, ad, 32'h0, q);
  endtask : rd
  task automatic mwr(input logic [7:0] ad, input logic [7:0] d);
    wr(APB_ADDR, {24'h0, ad});
    wr(APB_WDATA, {24'h0, d});
    wr(APB_CMD, 32'h2);
    repeat (2) @(negedge i_clk_sys);
  endtask : mwr
  task automatic mrd(input logic [7:0] ad);
    wr(APB_ADDR, {24'h0, ad});
    wr(APB_CMD, 32'h1);
    rd(APB_RDATA);
  endtask : mrd
  initial begin
    void'($urandom(32'h63bd));
    repeat (6) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(negedge i_clk_sys);
    chk(o_low_power, 1);
    chk(o_out_mute, 8'hff);
    chk(o_int_req, 0);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      a = (i < 4) ? {2'b01, r[5:0]} : {1'b1, r[6:0]};
      p = i % 4;
      k = a[7] ? p * 256 + a : a;
      wr(APB_PAGE, p);
      mwr(a, r[15:8]);
      mem[k] = r[15:8];
      qa.push_back(a);
      qk.push_back(k);
    end
    foreach (qa[i]) begin
      wr(APB_PAGE, qa[i][7] ? qk[i] / 256 : 3);
      mrd(qa[i]);
      chk(q, mem[qk[i]]);
    end
    v = 8'h01 | 8'($urandom);
    wr(APB_MASK, 32'h0);
    wr(APB_EVENT, {24'h0, v});
    @(negedge i_clk_sys);
    chk(o_int_req, 1);
    wr(APB_MASK, 32'hff);
    @(negedge i_clk_sys);
    chk(o_int_req, 0);
    mwr(MASK_BYTE, 8'h00);
    chk(o_int_req, 1);
    rd(APB_LATCH);
    chk(q, v);
    mrd(LATCH_BYTE);
    chk(q, v);
    mrd(LATCH_BYTE);
    chk(q, 0);
    chk(o_int_req, 0);
    mwr(POWER_BYTE, 8'h00);
    chk(o_low_power, 0);
    mrd(POWER_BYTE);
    chk(q, 0);
    wr(APB_POWER, 32'h1);
    @(negedge i_clk_sys);
    chk(o_low_power, 1);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      if (i == 0) r[7:0] = 8'hff;
      wr(APB_DIS, {24'h0, r[7:0]});
      i_no_input <= r[31:24];
      wr(APB_SQL, {24'h0, r[15:8]});
      wr(APB_AUTO, {24'h0, r[23:16]});
      repeat (2) @(negedge i_clk_sys);
      chk(o_out_mute, r[7:0] | r[15:8] | (r[23:16] & r[31:24]));
      rd(APB_MUTE);
      chk(q, {24'h0, r[7:0] | r[15:8] | (r[23:16] & r[31:24])});
    end
    wr(APB_ISTAT, 32'h7);
    wr(APB_IMASK, 32'h1);
    mrd(8'h00);
    chk(o_irq, 1);
    wr(APB_ISTAT, 32'h1);
    @(negedge i_clk_sys);
    chk(o_irq, 0);
    wr(APB_IMASK, 32'h4);
    wr(APB_EVENT, 32'h1);
    @(negedge i_clk_sys);
    chk(o_irq, 1);
    wr(APB_IMASK, 32'h0);
    @(negedge i_clk_sys);
    chk(o_irq, 0);
    rd(12'h03c);
    chk(q, 0);
    // both command bits set: the write must win
    v = 8'($urandom);
    wr(APB_ISTAT, 32'h7);
    wr(APB_ADDR, 32'h50);
    wr(APB_WDATA, {24'h0, v});
    wr(APB_CMD, 32'h3);
    repeat (2) @(negedge i_clk_sys);
    rd(APB_ISTAT);
    chk(q, 32'h2);
    mrd(8'h50);
    chk(q, {24'h0, v});
    final_report();
  end
endmodule : tb_top
bind mml_top mml_chk mml_chk_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_int_req(o_int_req),
  .o_irq(o_irq), .o_low_power(o_low_power), .o_out_mute(o_out_mute));
